// file: verilog/fpa_frontend.sv
// fpa_frontend: SPI instruction framing, extended address register,
// write-protect decode and id read-out of a serial flash
// assumes: host drives CS_B, SCLK, SERIAL_IN_LINE; array engine outside
//
// Behaviour
// - complement bit with scheme select clear protects the complement of top/bottom range, nothing if top_bottom_select set and block_protect 0.
// - erase or program touching any protected block is dropped.
// - lock bits count only while protect scheme select is one.
// - all lock bits are one after power-up or reset.
// - volatile 8-bit extended address register, read C8h, written C5h.
// - extended register supplies upper bits only in 3-byte mode.
// - extended bits 1:0 (address bits 25:24) pick one of four 16MB regions.
// - four-byte opcodes take bits 31:24 from the received fourth byte.
// - address default bit or B7h forces 4-byte addressing for everything.
// - a received fourth address byte never alters the extended register.
// - extended register clears on power-up, hardware and software reset.
// - chip select low starts an instruction; first eight bits are opcode.
// - input sampled on rising serial clock, most significant bit first.
// - address, data and dummy bytes follow the opcode as needed.
// - chip select rising ends the instruction.
// - reads may end after any bit.
// - write, program, erase need whole bytes at chip select rise.
// - while busy only status register read is honoured; this block honours nothing while busy and never answers 05h.
// - id opcodes 90, 9F return manufacturer and device codes, AB the device code only.
// - scheme select picks range protection or per-block locks.
`timescale 1ns/1ns
`default_nettype none
module fpa_frontend (
    // system clock and reset
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_B,
    // serial link
    input  wire logic                 SCLK,
    input  wire logic                 CS_B,
    input  wire logic                 SERIAL_IN_LINE,
    output logic                      SERIAL_OUT,
    output logic                      SERIAL_OUT_OE,
    // configuration and status
    input  wire fpa_pkg::fpa_prot_t   PROT_CFG,
    input  wire logic                 POWERUP_ADDR_MODE_DEFAULT,
    input  wire logic                 SOFT_RESET,
    input  wire logic                 BUSY,
    input  wire logic                 LOCK_SET,
    input  wire logic                 LOCK_CLR,
    input  wire logic [9:0]           LOCK_IDX,
    output logic                      CURRENT_ADDR_MODE_FLAG,
    output logic [7:0]                EXT_ADDR,
    // array requests
    output fpa_pkg::fpa_req_t         ARRAY_REQ,
    output logic                      ARRAY_REQ_VALID,
    output logic                      ARRAY_REQ_BLOCKED
);
    // ----------------------------------------------------------------
    // link domain: shift in, count bits, serve read-outs
    // ----------------------------------------------------------------
    logic [7:0]  sh;
    logic [15:0] nbits;
    logic [7:0]  opc;
    logic [31:0] addr_sh;
    logic [7:0]  data_byte;
    logic        data_seen;
    logic        in_frame;
    logic [7:0]  tx;
    logic [7:0]  ext_l1;
    logic [7:0]  ext_l2;
    logic        busy_l1;
    logic        busy_l2;
    wire  [15:0] cur_nbits  = in_frame ? nbits : 16'h0000;
    wire  [7:0]  next_sh    = {sh[6:0], SERIAL_IN_LINE};
    wire  [15:0] next_nbits = cur_nbits + 16'h0001;

    // cross to link: slowly changing levels, double registered
    always_ff @(posedge SCLK or posedge CS_B) begin
        if (CS_B) begin
            ext_l1 <= 8'h00;
            ext_l2 <= 8'h00;
            busy_l1 <= 1'b0;
            busy_l2 <= 1'b0;
        end else begin
            ext_l1 <= EXT_ADDR;
            ext_l2 <= ext_l1;
            busy_l1 <= BUSY;
            busy_l2 <= busy_l1;
        end
    end

    // frame flag: cs high clears it, first sclk rise of a frame sets it
    always_ff @(posedge SCLK or posedge CS_B) begin
        if (CS_B) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    // capture: contents survive cs rise so the decode side can read them
    always_ff @(posedge SCLK) begin
        sh <= next_sh;
        if (cur_nbits != 16'hFFFF) begin
            nbits <= next_nbits;
        end
        if (!in_frame) begin
            opc <= 8'h00;
        end else if (cur_nbits == 16'd7) begin
            opc <= next_sh;
        end
        if (!in_frame) begin
            addr_sh <= 32'h0;
            data_seen <= 1'b0;
        end else if (cur_nbits[2:0] == 3'd7 && cur_nbits > 16'd7) begin
            if (cur_nbits < 16'd40) begin
                addr_sh <= {addr_sh[23:0], next_sh};
            end
            if (!data_seen) begin
                data_byte <= next_sh;
                data_seen <= 1'b1;
            end
        end
    end

    // read-out, presented on falling edge, legal to stop anywhere
    function automatic logic [7:0] id_byte(input logic [7:0] op, input logic [15:0] b);
        id_byte = 8'h00;
        case (op)
            fpa_pkg::OP_ID_AB: id_byte = fpa_pkg::DEV_CODE8;
            fpa_pkg::OP_ID_90: id_byte = (b[15:3] == 13'd4) ? fpa_pkg::MFR_CODE : fpa_pkg::DEV_CODE8;
            fpa_pkg::OP_ID_9F: id_byte = (b[15:3] == 13'd1) ? fpa_pkg::MFR_CODE
                                       : (b[15:3] == 13'd2) ? fpa_pkg::DEV_CODE16[15:8]
                                       : fpa_pkg::DEV_CODE16[7:0];
            fpa_pkg::OP_RD_EXT: id_byte = ext_l2;
            default: id_byte = 8'h00;
        endcase
    endfunction

    wire [7:0] out_byte = id_byte(opc, nbits);

    always_ff @(negedge SCLK or posedge CS_B) begin
        if (CS_B) begin
            tx <= 8'h00;
            SERIAL_OUT <= 1'b0;
            SERIAL_OUT_OE <= 1'b0;
        end else if (nbits >= 16'd8 && nbits[2:0] == 3'd0) begin
            SERIAL_OUT_OE <= !busy_l2 && (opc == fpa_pkg::OP_ID_AB && nbits >= 16'd32 ||
                             opc == fpa_pkg::OP_ID_90 && nbits >= 16'd32 ||
                             opc == fpa_pkg::OP_ID_9F || opc == fpa_pkg::OP_RD_EXT);
            tx <= {out_byte[6:0], 1'b0};
            SERIAL_OUT <= out_byte[7];
        end else begin
            SERIAL_OUT <= tx[7];
            tx <= {tx[6:0], 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // crossing to REF_CLK: frame end seen from CS level
    // ----------------------------------------------------------------
    logic cs_s1, cs_s2, cs_s3;
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
        end else begin
            cs_s1 <= CS_B;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
        end
    end
    wire frame_end = cs_s2 && !cs_s3;
    // link registers hold still while CS is high, so they are safe to sample here

    // ----------------------------------------------------------------
    // instruction decode at frame end
    // ----------------------------------------------------------------
    function automatic logic [1:0] op_kind(input logic [7:0] op);  // 0 none,1 addr3,2 addr4,3 chip
        case (op)
            fpa_pkg::OP_PP3, fpa_pkg::OP_SE3, fpa_pkg::OP_BE32, fpa_pkg::OP_BE64: op_kind = 2'd1;
            fpa_pkg::OP_PP4, fpa_pkg::OP_SE4, fpa_pkg::OP_BE64_4: op_kind = 2'd2;
            fpa_pkg::OP_CE_A, fpa_pkg::OP_CE_B: op_kind = 2'd3;
            default: op_kind = 2'd0;
        endcase
    endfunction

    wire  [1:0]  kind     = op_kind(opc);
    wire         aligned  = (nbits[2:0] == 3'd0);
    wire         use4     = (kind == 2'd2) || CURRENT_ADDR_MODE_FLAG;
    wire  [15:0] need     = use4 ? 16'd40 : 16'd32;
    // extended register fills the top byte only for 3-byte opcodes in 3-byte mode
    wire  [31:0] eff_addr = (kind == 2'd2) ? addr_sh : (CURRENT_ADDR_MODE_FLAG ? addr_sh
                            : {EXT_ADDR, addr_sh[23:0]});
    wire         pgm      = (opc == fpa_pkg::OP_PP3 || opc == fpa_pkg::OP_PP4);
    wire  [15:0] fmin     = pgm ? need + 16'd8 : need;
    wire         wr_ok    = aligned && (kind == 2'd3 ? nbits == 16'd8 : nbits == need || pgm && nbits >= fmin);

    // ----------------------------------------------------------------
    // protection decode
    // ----------------------------------------------------------------
    logic [fpa_pkg::NUM_BLK-1:0] lock;
    function automatic logic range_hit(input fpa_pkg::fpa_prot_t p, input logic [9:0] b);
        logic [10:0] span;
        logic        in;
        span = 11'd0;
        in = 1'b0;
        if (p.block_protect >= fpa_pkg::BP_ALL_MIN) span = 11'd1024;
        else if (p.block_protect != 4'h0) span = 11'd1 << (p.block_protect - 4'h1);
        if (p.top_bottom_select) in = ({1'b0, b} < span);
        else in = ({1'b0, b} >= 11'd1024 - span);
        range_hit = p.protect_complement ? !in : in;
        if (p.protect_complement && p.top_bottom_select && p.block_protect == 4'h0)
            range_hit = 1'b0;
    endfunction

    wire [9:0] blk = eff_addr[fpa_pkg::BLK_LSB +: fpa_pkg::BLK_BITS];
    logic any_prot;
    always_comb begin
        any_prot = 1'b0;
        if (kind == 2'd3) begin
            for (int i = 0; i < fpa_pkg::NUM_BLK; i++)
                any_prot = any_prot | (PROT_CFG.protect_scheme_select ? lock[i]
                                      : range_hit(PROT_CFG, 10'(i)));
        end else begin
            any_prot = PROT_CFG.protect_scheme_select ? lock[blk] : range_hit(PROT_CFG, blk);
        end
    end

    // ----------------------------------------------------------------
    // lock bits
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            lock <= '1;
        end else if (SOFT_RESET) begin
            lock <= '1;
        end else if (LOCK_SET) begin
            lock[LOCK_IDX] <= 1'b1;
        end else if (LOCK_CLR) begin
            lock[LOCK_IDX] <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // address mode and extended address register
    // ----------------------------------------------------------------
    logic mode_init;
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CURRENT_ADDR_MODE_FLAG <= 1'b0;
            mode_init <= 1'b0;
        end else if (!mode_init || SOFT_RESET) begin
            CURRENT_ADDR_MODE_FLAG <= POWERUP_ADDR_MODE_DEFAULT;
            mode_init <= 1'b1;
        end else if (frame_end && !BUSY && opc == fpa_pkg::OP_EN4B && nbits == 16'd8) begin
            CURRENT_ADDR_MODE_FLAG <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            EXT_ADDR <= fpa_pkg::EXT_RESET;
        end else if (SOFT_RESET) begin
            EXT_ADDR <= fpa_pkg::EXT_RESET;
        end else if (frame_end && !BUSY && opc == fpa_pkg::OP_WR_EXT && aligned && nbits >= 16'd16) begin
            EXT_ADDR <= data_byte;
        end
    end

    // ----------------------------------------------------------------
    // array request issue
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ARRAY_REQ <= '0;
            ARRAY_REQ_VALID <= 1'b0;
            ARRAY_REQ_BLOCKED <= 1'b0;
        end else begin
            ARRAY_REQ_VALID <= 1'b0;
            ARRAY_REQ_BLOCKED <= 1'b0;
            if (frame_end && !BUSY && kind != 2'd0 && wr_ok) begin
                ARRAY_REQ.is_erase <= !pgm;
                ARRAY_REQ.is_chip  <= (kind == 2'd3);
                ARRAY_REQ.addr     <= eff_addr;
                ARRAY_REQ_VALID    <= !any_prot;
                ARRAY_REQ_BLOCKED  <= any_prot;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_frame_ok;
        frame_end && !BUSY && kind != 2'd0 && wr_ok;
    endsequence
    chk_prot_blocks: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        s_frame_ok and any_prot |=> ARRAY_REQ_BLOCKED && !ARRAY_REQ_VALID) else $error("protected target issued");
    chk_busy_ignore: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        BUSY |=> !ARRAY_REQ_VALID && !ARRAY_REQ_BLOCKED) else $error("request while busy");
    chk_unaligned_drop: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        frame_end && !aligned |=> !ARRAY_REQ_VALID) else $error("unaligned write accepted");
    chk_ext_upper: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        ARRAY_REQ_VALID && $past(kind) == 2'd1 && !$past(CURRENT_ADDR_MODE_FLAG)
        |-> ARRAY_REQ.addr[31:24] == $past(EXT_ADDR)) else $error("extended bits not applied");
    chk_four_byte: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        ARRAY_REQ_VALID && $past(kind) == 2'd2 |-> ARRAY_REQ.addr == $past(addr_sh)) else $error("4-byte address wrong");
    chk_ext_stable: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !(frame_end && opc == fpa_pkg::OP_WR_EXT) && !SOFT_RESET |=> $stable(EXT_ADDR)) else $error("ext reg changed");
    chk_soft_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        SOFT_RESET |=> EXT_ADDR == fpa_pkg::EXT_RESET) else $error("ext reg not cleared");
    chk_lock_reset: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        SOFT_RESET |=> &lock) else $error("locks not set");
    chk_mode_sticky: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        mode_init && CURRENT_ADDR_MODE_FLAG && !SOFT_RESET |=> CURRENT_ADDR_MODE_FLAG) else $error("mode dropped");
    chk_req_exclusive: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        ARRAY_REQ_VALID |-> !ARRAY_REQ_BLOCKED) else $error("request both issued and blocked");
    chk_unknown_drop: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        frame_end && kind == 2'd0 |=> !ARRAY_REQ_VALID && !ARRAY_REQ_BLOCKED) else $error("unknown opcode acted on");
    chk_enter_four: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        mode_init && !SOFT_RESET && frame_end && !BUSY && opc == fpa_pkg::OP_EN4B && nbits == 16'd8
        |=> CURRENT_ADDR_MODE_FLAG) else $error("4-byte mode not entered");
    chk_lock_block: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        s_frame_ok and PROT_CFG.protect_scheme_select && kind != 2'd3 && lock[blk]
        |=> ARRAY_REQ_BLOCKED) else $error("locked block not protected");
endmodule : fpa_frontend
`default_nettype wire

// file: verilog/fpa_pkg.sv
// fpa_pkg: constants and carrier types for the serial flash protect/address front end
// assumes: used by fpa_frontend and its test bench, referenced as fpa_pkg::name
package fpa_pkg;
    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_RD_EXT   = 8'hC8;
    localparam logic [7:0] OP_WR_EXT   = 8'hC5;
    localparam logic [7:0] OP_EN4B     = 8'hB7;
    localparam logic [7:0] OP_ID_AB    = 8'hAB;
    localparam logic [7:0] OP_ID_90    = 8'h90;
    localparam logic [7:0] OP_ID_9F    = 8'h9F;
    localparam logic [7:0] OP_RDSR1    = 8'h05;
    localparam logic [7:0] OP_READ3    = 8'h03;
    localparam logic [7:0] OP_READ4    = 8'h13;
    localparam logic [7:0] OP_FREAD3   = 8'h0B;
    localparam logic [7:0] OP_FREAD4   = 8'h0C;
    localparam logic [7:0] OP_PP3      = 8'h02;
    localparam logic [7:0] OP_PP4      = 8'h12;
    localparam logic [7:0] OP_SE3      = 8'h20;
    localparam logic [7:0] OP_SE4      = 8'h21;
    localparam logic [7:0] OP_BE32     = 8'h52;
    localparam logic [7:0] OP_BE64     = 8'hD8;
    localparam logic [7:0] OP_BE64_4   = 8'hDC;
    localparam logic [7:0] OP_CE_A     = 8'hC7;
    localparam logic [7:0] OP_CE_B     = 8'h60;
    // identity values are arbitrary
    localparam logic [7:0]  MFR_CODE   = 8'h5A;
    localparam logic [7:0]  DEV_CODE8  = 8'h3C;
    localparam logic [15:0] DEV_CODE16 = 16'h1234;
    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int BLK_LSB    = 16;
    localparam int BLK_BITS   = 10;
    localparam int NUM_BLK    = 1024;
    localparam int BYTE_BITS  = 8;
    localparam int REGION_LSB = 24;
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [3:0] BP_ALL_MIN = 4'hB;
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       protect_scheme_select;
        logic       protect_complement;
        logic       top_bottom_select;
        logic [3:0] block_protect;
    } fpa_prot_t;
    typedef struct packed {
        logic        is_erase;
        logic        is_chip;
        logic [31:0] addr;
    } fpa_req_t;
endpackage : fpa_pkg

// file: dv/fpa_host_model.sv
// fpa_host_model: behavioural SPI host issuing flash instructions
// assumes: device samples mosi on sclk rise and drives miso on sclk fall
`timescale 1ns/1ns
`default_nettype none
module fpa_host_model (
    // serial link
    output logic      sclk,
    output logic      cs_b,
    output logic      mosi,
    input  wire logic miso
);
    // ----------------------------------------------------------------
    // frame driver
    // ----------------------------------------------------------------
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        mosi = 1'b0;
    end
    // sends nbits from tx[63] downwards, clock stands still outside frames
    task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx);
        rx = 64'h0;
        cs_b = 1'b0;
        #20;
        for (int i = 0; i < nbits; i++) begin
            mosi = tx[63 - i];
            #15;
            sclk = 1'b1;
            rx = {rx[62:0], miso};
            #15;
            sclk = 1'b0;
        end
        #20;
        cs_b = 1'b1;
        mosi = ~mosi;
    endtask : frame
endmodule : fpa_host_model
`default_nettype wire

// file: dv/fpa_frontend_tb_top.sv
// fpa_frontend_tb_top: self-checking bench for the flash front end
// assumes: fpa_host_model drives the link, array engine modelled by counters
`timescale 1ns/1ns
`default_nettype none
module fpa_frontend_tb_top;
    logic               ref_clk, rst_b, sclk, cs_b, mosi, miso, miso_oe, pu_dflt, soft_rst, busy;
    logic               lock_set, lock_clr, mode_flag, req_valid, req_blocked, p, oe_seen;
    logic [9:0]         lock_idx, blk;
    logic [7:0]         ext_addr, ev;
    logic [31:0]        a, r;
    logic [63:0]        rx;
    fpa_pkg::fpa_prot_t prot;
    fpa_pkg::fpa_req_t  req, last_req;
    int                 errors, check_count, n_valid, n_blk;
    logic [5:0]         cfg_tab [4] = '{6'h21, 6'h21, 6'h31, 6'h31};
    logic [9:0]         blk_tab [4] = '{10'd1023, 10'd1022, 10'd0, 10'd1};

    fpa_host_model host_u (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));
    fpa_frontend dut_u (
        .REF_CLK(ref_clk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b), .SERIAL_IN_LINE(mosi),
        .SERIAL_OUT(miso), .SERIAL_OUT_OE(miso_oe), .PROT_CFG(prot), .POWERUP_ADDR_MODE_DEFAULT(pu_dflt),
        .SOFT_RESET(soft_rst), .BUSY(busy), .LOCK_SET(lock_set), .LOCK_CLR(lock_clr), .LOCK_IDX(lock_idx),
        .CURRENT_ADDR_MODE_FLAG(mode_flag), .EXT_ADDR(ext_addr), .ARRAY_REQ(req),
        .ARRAY_REQ_VALID(req_valid), .ARRAY_REQ_BLOCKED(req_blocked));

    // ----------------------------------------------------------------
    // clock, request monitor, helpers
    // ----------------------------------------------------------------
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (req_valid === 1'b1) begin
            n_valid++;
            last_req = req;
        end
        if (req_blocked === 1'b1) n_blk++;
    end
    always @(posedge sclk) begin
        if (miso_oe === 1'b1) oe_seen = 1'b1;
    end
    // expected protection for scheme select clear
    function automatic logic is_prot(logic [5:0] cfg, logic [9:0] b);
        int  n;
        logic q;
        n = (cfg[3:0] == 4'h0) ? 0 : (cfg[3:0] >= 4'hB) ? 1024 : (1 << (cfg[3:0] - 1));
        q = cfg[4] ? (int'(b) < n) : (int'(b) >= 1024 - n);
        if (cfg[5]) q = (n == 0 && cfg[4]) ? 1'b0 : !q;
        return q;
    endfunction : is_prot
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic send(input logic [63:0] tx, input int nbits);
        n_valid = 0;
        n_blk = 0;
        oe_seen = 1'b0;
        host_u.frame(tx, nbits, rx);
        repeat (8) @(negedge ref_clk);
    endtask : send
    task automatic erase_chk(input logic [63:0] tx, input int nbits, input logic [31:0] ea, input logic bl);
        send(tx, nbits);
        chk({n_valid, n_blk}, {31'h0, ~bl, 31'h0, bl});
        if (!bl) chk({last_req.is_erase, last_req.addr}, {1'b1, ea});
    endtask : erase_chk
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask : pulse
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        #2000000;
        errors++;
        end_of_test();
    end
    initial begin
        {ref_clk, rst_b, pu_dflt, soft_rst, busy, lock_set, lock_clr} = 7'h0;
        lock_idx = 10'h0;
        prot = '0;
        errors = 0;
        check_count = 0;
        r = $urandom(32'hA089C01D);
        repeat (12) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge ref_clk);
        chk({ext_addr, mode_flag}, {8'h00, 1'b0});
        r = $urandom;
        send({fpa_pkg::OP_WR_EXT, r[7:0], 48'h0}, 16);
        chk(ext_addr, r[7:0]);
        send({fpa_pkg::OP_ID_9F, 56'h0}, 13);
        send({fpa_pkg::OP_RD_EXT, 56'h0}, 16);
        chk(rx[7:0], r[7:0]);
        for (int i = 0; i < 4; i++) begin
            ev = 8'(i);
            r = $urandom;
            send({fpa_pkg::OP_WR_EXT, ev, 48'h0}, 16);
            erase_chk({fpa_pkg::OP_SE3, r[23:0], 32'h0}, 32, {ev, r[23:0]}, 1'b0);
        end
        a = {6'h0, r[25:0]};
        erase_chk({fpa_pkg::OP_SE4, a, 24'h0}, 40, a, 1'b0);
        chk(ext_addr, ev);
        send({fpa_pkg::OP_ID_9F, 56'h0}, 32);
        chk(rx[23:0], {fpa_pkg::MFR_CODE, fpa_pkg::DEV_CODE16});
        chk(oe_seen, 1'b1);
        send({fpa_pkg::OP_ID_90, 56'h0}, 48);
        chk(rx[15:0], {fpa_pkg::MFR_CODE, fpa_pkg::DEV_CODE8});
        send({fpa_pkg::OP_ID_AB, 56'h0}, 40);
        chk(rx[7:0], fpa_pkg::DEV_CODE8);
        $display("done: extended address and ids");
        send({fpa_pkg::OP_SE3, r[23:0], 32'h0}, 31);
        chk({n_valid, n_blk}, 64'h0);
        chk(oe_seen, 1'b0);
        send({8'hFF, r[23:0], 32'h0}, 32);
        chk({n_valid, n_blk}, 64'h0);
        busy = 1'b1;
        send({fpa_pkg::OP_SE3, r[23:0], 32'h0}, 32);
        send({fpa_pkg::OP_WR_EXT, 8'hA5, 48'h0}, 16);
        chk({n_valid, n_blk, 24'h0, ext_addr}, {64'h0, 24'h0, ev});
        busy = 1'b0;
        $display("done: refused frames");
        for (int i = 0; i < 20; i++) begin
            r = $urandom;
            prot = {1'b0, (i < 4) ? cfg_tab[i] : r[5:0]};
            blk = (i < 4) ? blk_tab[i] : r[15:6];
            a = {6'h0, blk, r[31:16]};
            p = is_prot(prot[5:0], blk);
            erase_chk({fpa_pkg::OP_SE4, a, 24'h0}, 40, a, p);
        end
        prot = '0;
        prot.protect_scheme_select = 1'b1;
        lock_idx = blk;
        erase_chk({fpa_pkg::OP_SE4, a, 24'h0}, 40, a, 1'b1);
        pulse(lock_clr);
        erase_chk({fpa_pkg::OP_SE4, a, 24'h0}, 40, a, 1'b0);
        pulse(lock_set);
        erase_chk({fpa_pkg::OP_SE4, a, 24'h0}, 40, a, 1'b1);
        prot = '0;
        $display("done: protection");
        send({fpa_pkg::OP_EN4B, 56'h0}, 8);
        chk(mode_flag, 1'b1);
        erase_chk({fpa_pkg::OP_SE3, a, 24'h0}, 40, a, 1'b0);
        pu_dflt = 1'b1;
        pulse(soft_rst);
        chk({ext_addr, mode_flag}, {8'h00, 1'b1});
        pu_dflt = 1'b0;
        pulse(soft_rst);
        chk(mode_flag, 1'b0);
        prot.protect_scheme_select = 1'b1;
        erase_chk({fpa_pkg::OP_SE4, a, 24'h0}, 40, a, 1'b1);
        $display("done: address mode and soft reset");
        end_of_test();
    end
endmodule : fpa_frontend_tb_top
`default_nettype wire
